// *** hdl/qpt_pkg.sv ***
// Package for the quad pot terminal and wiper control block.
// Assumes one 100 MHz clock and a command front end that delivers decoded register commands.
package qpt_pkg;

  // ==========================================================================
  // Register addresses and widths
  localparam logic [3:0] ADDR_WIPER0 = 4'h0;
  localparam logic [3:0] ADDR_WIPER1 = 4'h1;
  localparam logic [3:0] ADDR_TERM01 = 4'h4;
  localparam logic [3:0] ADDR_WIPER2 = 4'h6;
  localparam logic [3:0] ADDR_WIPER3 = 4'h7;
  localparam logic [3:0] ADDR_TERM23 = 4'ha;
  localparam int WIPER_W = 10;
  localparam int TAP_N = 257;
  localparam int NET_N = 4;

  // ==========================================================================
  // Terminal control field positions
  localparam int FLD_FIXED_ONE = 8;
  localparam int FLD_HI_FORCE_N = 7;
  localparam int FLD_HI_A = 6;
  localparam int FLD_HI_W = 5;
  localparam int FLD_HI_B = 4;
  localparam int FLD_LO_FORCE_N = 3;
  localparam int FLD_LO_A = 2;
  localparam int FLD_LO_W = 1;
  localparam int FLD_LO_B = 0;

  // ==========================================================================
  // Reset values and scale figures
  localparam logic [8:0] TERM_RST = 9'h1ff;
  localparam logic [9:0] WIPER_RST_8B = 10'h080;
  localparam logic [9:0] WIPER_RST_7B = 10'h040;
  localparam logic [9:0] FULL_8B = 10'h100;
  localparam logic [9:0] FULL_7B = 10'h080;
  localparam logic [9:0] ZERO_SCALE = 10'h000;

  // ==========================================================================
  // Commands
  typedef enum logic [1:0] {
    CMD_WRITE = 2'h0,
    CMD_INC = 2'h1,
    CMD_DEC = 2'h2,
    CMD_READ = 2'h3
  } qpt_cmd_t;

  // Command from the serial front end, valid for one cycle when complete
  typedef struct packed {
    logic valid;
    qpt_cmd_t cmd;
    logic [3:0] addr;
    logic [9:0] data;
  } qpt_req_t;

  // Per-network terminal switch state
  typedef struct packed {
    logic a_on;
    logic w_on;
    logic b_on;
    logic w_to_b;
  } qpt_term_t;

  // Execution states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } qpt_state_t;

endpackage

// *** hdl/qpt_tap_decode.sv ***
// Decoder from a wiper value to a one-hot tap switch select, registered.
// Assumes the value is held in the same clock domain.
`timescale 1ns/1ns
module qpt_tap_decode
  import qpt_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Wiper value and resolution
  input wire logic [9:0] wiper_i,
  input wire logic res8_i,
  // One-hot tap select, bit 0 is terminal B
  output logic [TAP_N-1:0] tap_sel_o
);

  logic [TAP_N-1:0] tap_sel_ff;
  logic [TAP_N-1:0] nxt_tap_sel;
  logic [9:0] full;

  // Saturate reserved codes to full scale, then one-hot
  always_comb begin
    full = res8_i ? FULL_8B : FULL_7B;
    nxt_tap_sel = '0;
    if (wiper_i >= full) begin
      nxt_tap_sel[full[8:0]] = 1'b1;
    end else begin
      nxt_tap_sel[wiper_i[8:0]] = 1'b1;
    end
  end

  // Register the select
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tap_sel_ff <= '0;
    end else begin
      tap_sel_ff <= nxt_tap_sel;
    end
  end

  assign tap_sel_o = tap_sel_ff;

endmodule // qpt_tap_decode

// *** hdl/qpt_top.sv ***
// Contract
// - Terminal control bit 8 always reads one, writes ignored.
// - Network 3 force bit low puts network 3 in shutdown.
// - Network 3 A-connect bit connects terminal A when one.
// - Network 3 wiper-connect bit connects wiper when one.
// - Network 3 B-connect bit connects terminal B when one.
// - Network 2 force bit low puts network 2 in shutdown.
// - Network 2 A, W, B connect bits connect each terminal.
// - Terminal control writes never alter stored wiper values.
// - Wiper value decodes to one-hot tap select per network.
// - Zero selects terminal B; decrement at zero ignored.
// - Full scale selects terminal A; increment there ignored.
// - Codes above full scale act full; inc and dec ignored.
// - Eight-bit option has 257 wiper positions.
// - Seven-bit option has 129 wiper positions.
// - Four independent networks with own wiper and terminal bits.
// - Shutdown reached only through terminal control writes.
// - Shutdown opens terminal A and ties wiper to terminal B.
// - Connect bits kept during shutdown, govern again after release.
// - Terminal writes reach terminals only after command completes.
// - Reset loads all terminal control registers with 1ff.
//
// Top of the quad pot digital control: wipers, terminal control, switch drive.
// Assumes a serial front end on the same clock that gives one pulse per
// completed command; no shutdown pin exists.
`timescale 1ns/1ns
module qpt_top
  import qpt_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Option strap, high for the 8-bit ladder
  input wire logic res8_i,
  // Completed command from the serial front end
  input wire qpt_req_t req_i,
  // Read answer and command status
  output logic [9:0] rd_data_o,
  output logic rd_valid_o,
  output logic cmd_err_o,
  // Terminal switches per network
  output qpt_term_t [NET_N-1:0] term_o,
  // Tap selects per network
  output logic [NET_N-1:0][TAP_N-1:0] tap_sel_o
);

  // ==========================================================================
  // Declarations
  logic [NET_N-1:0][9:0] wiper_ff;
  logic [8:0] term01_ff;
  logic [8:0] term23_ff;
  logic [9:0] rd_data_ff;
  logic rd_valid_ff;
  logic cmd_err_ff;
  qpt_term_t [NET_N-1:0] term_ff;
  qpt_term_t [NET_N-1:0] nxt_term;
  qpt_state_t state_ff;
  logic res8_s1_ff;
  logic res8_ff;
  logic [9:0] full;
  logic [2:0] net_idx;
  logic is_wiper;
  logic is_term;

  // Map an address to a network index, bit 2 flags a miss
  function automatic logic [2:0] wiper_net(input logic [3:0] addr);
    case (addr)
      ADDR_WIPER0: wiper_net = 3'h0;
      ADDR_WIPER1: wiper_net = 3'h1;
      ADDR_WIPER2: wiper_net = 3'h2;
      ADDR_WIPER3: wiper_net = 3'h3;
      default: wiper_net = 3'h4;
    endcase
  endfunction

  // Switch state from force, A, W, B bits
  function automatic qpt_term_t term_map(input logic force_n, input logic a,
                                         input logic w, input logic b);
    qpt_term_t t;
    t = '0;
    if (!force_n) begin
      t.a_on = 1'b0;
      t.w_on = 1'b1;
      t.b_on = 1'b1;
      t.w_to_b = 1'b1;
    end else begin
      t.a_on = a;
      t.w_on = w;
      t.b_on = b;
      t.w_to_b = 1'b0;
    end
    term_map = t;
  endfunction

  // ==========================================================================
  // Strap synchroniser
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      res8_s1_ff <= 1'b1;
      res8_ff <= 1'b1;
    end else begin
      res8_s1_ff <= res8_i;
      res8_ff <= res8_s1_ff;
    end
  end

  // Decode helpers
  always_comb begin
    full = res8_ff ? FULL_8B : FULL_7B;
    net_idx = wiper_net(req_i.addr);
    is_wiper = !net_idx[2];
    is_term = (req_i.addr == ADDR_TERM01) || (req_i.addr == ADDR_TERM23);
  end

  // ==========================================================================
  // Wiper registers, touched only by wiper commands
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NET_N; i++) begin
        wiper_ff[i] <= WIPER_RST_8B;
      end
    end else if (state_ff == ST_IDLE && req_i.valid && is_wiper) begin
      case (req_i.cmd)
        CMD_WRITE: wiper_ff[net_idx[1:0]] <= req_i.data;
        CMD_INC: begin
          if (wiper_ff[net_idx[1:0]] < full) begin
            wiper_ff[net_idx[1:0]] <= wiper_ff[net_idx[1:0]] + 10'h001;
          end
        end
        CMD_DEC: begin
          if (wiper_ff[net_idx[1:0]] != ZERO_SCALE
              && wiper_ff[net_idx[1:0]] <= full) begin
            wiper_ff[net_idx[1:0]] <= wiper_ff[net_idx[1:0]] - 10'h001;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Terminal control registers; only software writes reach shutdown
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      term01_ff <= TERM_RST;
      term23_ff <= TERM_RST;
    end else if (state_ff == ST_IDLE && req_i.valid && req_i.cmd == CMD_WRITE) begin
      if (req_i.addr == ADDR_TERM01) begin
        term01_ff <= {1'b1, req_i.data[7:0]};
      end
      if (req_i.addr == ADDR_TERM23) begin
        term23_ff <= {1'b1, req_i.data[7:0]};
      end
    end
  end

  // ==========================================================================
  // Terminal switch map; stored bits survive shutdown
  always_comb begin
    nxt_term[0] = term_map(term01_ff[FLD_LO_FORCE_N], term01_ff[FLD_LO_A],
                           term01_ff[FLD_LO_W], term01_ff[FLD_LO_B]);
    nxt_term[1] = term_map(term01_ff[FLD_HI_FORCE_N], term01_ff[FLD_HI_A],
                           term01_ff[FLD_HI_W], term01_ff[FLD_HI_B]);
    nxt_term[2] = term_map(term23_ff[FLD_LO_FORCE_N], term23_ff[FLD_LO_A],
                           term23_ff[FLD_LO_W], term23_ff[FLD_LO_B]);
    nxt_term[3] = term_map(term23_ff[FLD_HI_FORCE_N], term23_ff[FLD_HI_A],
                           term23_ff[FLD_HI_W], term23_ff[FLD_HI_B]);
  end

  // Drive switches from registered state, one cycle after the write lands
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NET_N; i++) begin
        // All networks start as the all-connected switch state of the reset word
        term_ff[i] <= term_map(TERM_RST[FLD_LO_FORCE_N], TERM_RST[FLD_LO_A],
                               TERM_RST[FLD_LO_W], TERM_RST[FLD_LO_B]);
      end
    end else begin
      term_ff <= nxt_term;
    end
  end

  // ==========================================================================
  // Command state: one answer cycle per accepted command
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: if (req_i.valid) state_ff <= ST_ANSWER;
        ST_ANSWER: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Read data, read strobe and error flag
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_data_ff <= 10'h000;
      rd_valid_ff <= 1'b0;
      cmd_err_ff <= 1'b0;
    end else begin
      rd_valid_ff <= 1'b0;
      cmd_err_ff <= 1'b0;
      if (state_ff == ST_IDLE && req_i.valid) begin
        if (req_i.cmd == CMD_READ) begin
          rd_valid_ff <= is_wiper || is_term;
          cmd_err_ff <= !(is_wiper || is_term);
          if (is_wiper) begin
            rd_data_ff <= wiper_ff[net_idx[1:0]];
          end else if (req_i.addr == ADDR_TERM01) begin
            rd_data_ff <= {1'b0, term01_ff};
          end else if (req_i.addr == ADDR_TERM23) begin
            rd_data_ff <= {1'b0, term23_ff};
          end else begin
            rd_data_ff <= 10'h000;
          end
        end else begin
          // Increment or decrement on terminal control, or any unmapped address
          cmd_err_ff <= !is_wiper && !(is_term && req_i.cmd == CMD_WRITE);
        end
      end
    end
  end

  // ==========================================================================
  // Tap decoders, one per network
  for (genvar g = 0; g < NET_N; g++) begin : g_tap
    qpt_tap_decode u_dec (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .wiper_i(wiper_ff[g]),
      .res8_i(res8_ff),
      .tap_sel_o(tap_sel_o[g])
    );
  end

  assign rd_data_o = rd_data_ff;
  assign rd_valid_o = rd_valid_ff;
  assign cmd_err_o = cmd_err_ff;
  assign term_o = term_ff;

endmodule // qpt_top

// *** bench/qpt_top_props.sv ***
// Port checker for the quad pot control top.
// Assumes requests come at least two idle cycles apart.
`timescale 1ns/1ns
module qpt_top_props
  import qpt_pkg::*;
(
  // Clock, reset, inputs
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic res8_i,
  input wire qpt_req_t req_i,
  // Watched outputs
  input wire logic [9:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic cmd_err_o,
  input wire qpt_term_t [NET_N-1:0] term_o,
  input wire logic [NET_N-1:0][TAP_N-1:0] tap_sel_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================================
  // Taken request: valid after a quiet cycle
  logic prev_v_ff;
  logic tk;
  always_ff @(posedge core_clk_i) begin
    prev_v_ff <= rst_n_i ? req_i.valid : 1'b0;
  end
  assign tk = req_i.valid && !prev_v_ff;
  logic wt;
  assign wt = tk && req_i.cmd == CMD_WRITE;
  // ==========================================================================
  // Assertions
  fixed_one_a: assert property (
    tk && req_i.cmd == CMD_READ && req_i.addr == ADDR_TERM23
    |-> ##1 rd_valid_o && rd_data_o[FLD_FIXED_ONE]) else $error("fixed bit not one");
  net3_on_a: assert property (
    wt && req_i.addr == ADDR_TERM23 && req_i.data[FLD_HI_FORCE_N]
    |-> ##2 term_o[3] == {$past(req_i.data[6:4], 2), 1'b0}) else $error("net3 switches");
  net3_off_a: assert property (
    wt && req_i.addr == ADDR_TERM23 && !req_i.data[FLD_HI_FORCE_N]
    |-> ##2 term_o[3] == 4'h7) else $error("net3 shutdown");
  net2_sw_a: assert property (
    wt && req_i.addr == ADDR_TERM23 |-> ##2 term_o[2] == ($past(req_i.data[3], 2) ?
    {$past(req_i.data[2:0], 2), 1'b0} : 4'h7)) else $error("net2 switches");
  one_hot_a: assert property (
    $past(rst_n_i) && $past(rst_n_i, 2) |-> $onehot(tap_sel_o[0]) && $onehot(tap_sel_o[1])
    && $onehot(tap_sel_o[2]) && $onehot(tap_sel_o[3])) else $error("tap not one-hot");
  zero_sel_a: assert property (
    wt && req_i.addr == ADDR_WIPER2 && req_i.data == ZERO_SCALE
    |-> ##2 tap_sel_o[2][0]) else $error("zero scale tap");
  full_sel_a: assert property (
    wt && req_i.addr == ADDR_WIPER3 && req_i.data >= (res8_i ? FULL_8B : FULL_7B)
    |-> ##2 tap_sel_o[3][res8_i ? 256 : 128]) else $error("full scale tap");
  unmapped_a: assert property (
    tk && !(req_i.addr inside {4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'ha})
    |-> ##1 cmd_err_o && !rd_valid_o) else $error("unmapped not refused");
  stable_term_a: assert property (
    !$past(req_i.valid, 2) |-> $stable(term_o)) else $error("terminals moved alone");
endmodule // qpt_top_props

bind qpt_top qpt_top_props u_props (.core_clk_i, .rst_n_i, .res8_i, .req_i, .rd_data_o,
  .rd_valid_o, .cmd_err_o, .term_o, .tap_sel_o);

// *** bench/qpt_host_model.sv ***
// Host controller model issuing completed register commands.
// Assumes the device takes a one-cycle valid pulse.
`timescale 1ns/1ns
module qpt_host_model
  import qpt_pkg::*;
(
  // Clock
  input wire logic core_clk_i,
  // Request towards the device
  output qpt_req_t req_o
);
  initial req_o = '0;
  // One command after two quiet cycles; released address and data lines show the inverse, command kept
  task automatic send(input qpt_cmd_t c, input logic [3:0] a, input logic [9:0] d);
    repeat (2) @(posedge core_clk_i);
    #1;
    req_o = '{1'b1, c, a, d};
    @(posedge core_clk_i);
    #1;
    req_o.valid = 1'b0;
    req_o.addr = ~a;
    req_o.data = ~d;
  endtask
endmodule // qpt_host_model

// *** bench/test_quad_pot_wiper_terminal_control.sv ***
// Self-checking bench for the quad pot control top.
// Assumes the host model and the bound checker.
`timescale 1ns/1ns
module test_quad_pot_wiper_terminal_control;
  import qpt_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic res8_i = 1'b1;
  qpt_req_t req;
  logic [9:0] rd_data;
  logic rd_valid;
  logic cmd_err;
  qpt_term_t [NET_N-1:0] term;
  logic [NET_N-1:0][TAP_N-1:0] tap;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000e715;
  // ==========================================================================
  // Clock, timeout, instances
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end
  qpt_host_model host (.core_clk_i(core_clk_i), .req_o(req));
  qpt_top uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .res8_i(res8_i), .req_i(req),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .cmd_err_o(cmd_err), .term_o(term),
    .tap_sel_o(tap));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Shutdown opens A and ties wiper to B
  function automatic qpt_term_t exp_term(input logic [3:0] f);
    return f[3] ? {f[2:0], 1'b0} : 4'h7;
  endfunction
  task automatic chk_val(input string nm, input logic [9:0] e, input logic [9:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_term(input string nm, input qpt_term_t e, input qpt_term_t g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [9:0] d);
    host.send(CMD_READ, a, 10'h000);
    chk_val("read valid", 10'h001, {9'h000, rd_valid});
    d = rd_data;
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    #2;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    logic [9:0] v;
    logic [9:0] d;
    logic [9:0] full;
    logic [9:0] w;
    repeat (5) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    rd(ADDR_TERM23, d);
    chk_val("term23 reset", 10'h1ff, d);
    rd(ADDR_TERM01, d);
    chk_val("term01 reset", 10'h1ff, d);
    chk_term("net3 reset", 4'he, term[3]);
    host.send(CMD_WRITE, ADDR_WIPER3, 10'h0a5);
    // Terminal writes, corners then random
    for (int i = 0; i < 24; i++) begin
      v = (i == 0) ? 10'h07f : (i == 1) ? 10'h077 : 10'(xorshift());
      host.send(CMD_WRITE, ADDR_TERM23, v);
      w = 10'(xorshift() % 257);
      host.send(CMD_WRITE, ADDR_WIPER2, w);
      settle();
      chk_term("net3", exp_term(v[7:4]), term[3]);
      chk_term("net2", exp_term(v[3:0]), term[2]);
      chk_term("net1", 4'he, term[1]);
      chk_val("tap2", 10'h001, {9'h000, tap[2][w]});
      rd(ADDR_TERM23, d);
      chk_val("term23", {2'b01, v[7:0]}, d);
      rd(ADDR_WIPER3, d);
      chk_val("wiper3", 10'h0a5, d);
    end
    // Wiper ends for both ladder options
    for (int r = 0; r < 2; r++) begin
      res8_i = (r == 0);
      full = res8_i ? FULL_8B : FULL_7B;
      settle();
      host.send(CMD_WRITE, ADDR_WIPER2, full - 10'h001);
      host.send(CMD_INC, ADDR_WIPER2, 10'h000);
      host.send(CMD_INC, ADDR_WIPER2, 10'h000);
      rd(ADDR_WIPER2, d);
      chk_val("inc at full", full, d);
      settle();
      chk_val("tap at full", 10'h001, {9'h000, tap[2][full]});
      host.send(CMD_WRITE, ADDR_WIPER2, 10'h000);
      host.send(CMD_DEC, ADDR_WIPER2, 10'h000);
      rd(ADDR_WIPER2, d);
      chk_val("dec at zero", 10'h000, d);
      host.send(CMD_WRITE, ADDR_WIPER3, 10'h3ff);
      host.send(CMD_INC, ADDR_WIPER3, 10'h000);
      host.send(CMD_DEC, ADDR_WIPER3, 10'h000);
      rd(ADDR_WIPER3, d);
      chk_val("reserved code", 10'h3ff, d);
    end
    host.send(CMD_READ, 4'h5, 10'h000);
    chk_val("unmapped", 10'h001, {9'h000, cmd_err});
    host.send(CMD_WRITE, 4'h2, 10'h000);
    chk_val("unmapped write", 10'h001, {9'h000, cmd_err});
    host.send(CMD_INC, ADDR_TERM23, 10'h000);
    chk_val("inc on term", 10'h001, {9'h000, cmd_err});
    finish_test();
  end
endmodule // test_quad_pot_wiper_terminal_control
